/* design/acr_consts.svh */
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
// Register indices; byte address is four times the index.
`define ACR_IDX_CONFIG 4'h9
`define ACR_IDX_OCAL_HIGH 4'ha
`define ACR_IDX_OCAL_LOW 4'hb
`define ACR_PHASE_MSB 15
`define ACR_PHASE_LSB 6
`define ACR_BYPASS_BIT 2
`define ACR_MUX_MSB 1
`define ACR_MUX_LSB 0
`define ACR_CONFIG_MASK 16'hffc7
`define ACR_OCAL_LOW_MASK 16'hff00
`define ACR_RESET_VALUE 16'h0000
`define ACR_RESP_OKAY 2'b00
`define ACR_RESP_SLVERR 2'b10
`endif

/* design/acr_pkg.sv */
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_IN_EXTERNAL = 2'b00,
    ACR_IN_SHORTED = 2'b01,
    ACR_IN_TEST_POS = 2'b10,
    ACR_IN_TEST_NEG = 2'b11
  } acr_input_t;
  typedef struct packed {
    logic [9:0] ch0_phase_delay;
    logic ch0_highpass_bypass;
    acr_input_t ch0_input_select;
  } acr_config_t;
endpackage : acr_pkg

/* design/acr_regs.sv */
`timescale 1ns/100ps
`include "acr_consts.svh"
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // The register bus follows AXI4-Lite.
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // The outputs below feed the modulator and filter datapath; global_dc_removal_setting is an input.
  output acr_config_t ch0_config_out,
  output logic signed [23:0] ch0_offset_value,
  input wire logic global_dc_removal_setting,
  output logic ch0_dc_removal_active
);
  // Stored images of the three registers, with reserved bits always zero.
  logic [15:0] ch0_config;
  logic [15:0] ch0_offset_cal_high;
  logic [15:0] ch0_offset_cal_low;
  logic [5:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [15:0] next_wval;
  logic [15:0] old_val;
  logic [3:0] w_idx;
  logic [3:0] r_idx;
  logic do_write;
  logic w_mapped;

  // Bits 1:0 of each address are ignored; every register is one aligned word.
  assign w_idx = aw_addr[5:2];
  assign r_idx = s_axi_araddr[5:2];
  // A write is carried out once both halves are held and no earlier response waits.
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // The old value is merged under the strobes, so a partial write keeps the other byte.
  always_comb begin
    unique case (w_idx)
      `ACR_IDX_CONFIG: old_val = ch0_config;
      `ACR_IDX_OCAL_HIGH: old_val = ch0_offset_cal_high;
      `ACR_IDX_OCAL_LOW: old_val = ch0_offset_cal_low;
      default: old_val = `ACR_RESET_VALUE;
    endcase
  end

  // Byte lanes 2 and 3 lie outside the 16-bit registers, so their strobes are ignored.
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    assign next_wval[lane*8 +: 8] =
      w_strb[lane] ? w_data[lane*8 +: 8] : old_val[lane*8 +: 8];
  end

  // One decode gives the response code, so it matches the indices that store data.
  always_comb begin
    unique case (w_idx)
      `ACR_IDX_CONFIG: w_mapped = 1'b1;
      `ACR_IDX_OCAL_HIGH: w_mapped = 1'b1;
      `ACR_IDX_OCAL_LOW: w_mapped = 1'b1;
      default: w_mapped = 1'b0;
    endcase
  end

  // Reset is synchronous, so every register below clears on an edge with rst_n low.
  // Address and data are latched independently so either may arrive first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  // Ready is withheld while a beat is held or a response waits, so one write is in flight.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // The response stands until the master takes it.
  // An unmapped index answers with a slave error and stores nothing.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_mapped ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The config register resets to zero, which selects the external input pair.
  // Reserved bits are masked at write so they can never read back as one.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_config <= `ACR_RESET_VALUE;
    end else if (do_write && w_idx == `ACR_IDX_CONFIG) begin
      ch0_config <= next_wval & `ACR_CONFIG_MASK;
    end
  end

  // The upper offset register takes all sixteen bits, so it needs no mask.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_offset_cal_high <= `ACR_RESET_VALUE;
    end else if (do_write && w_idx == `ACR_IDX_OCAL_HIGH) begin
      ch0_offset_cal_high <= next_wval;
    end
  end

  // Only the upper byte of the lower offset register is kept.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_offset_cal_low <= `ACR_RESET_VALUE;
    end else if (do_write && w_idx == `ACR_IDX_OCAL_LOW) begin
      ch0_offset_cal_low <= next_wval & `ACR_OCAL_LOW_MASK;
    end
  end

  // Arready comes back a cycle after the answer is taken, so one read is in flight.
  // Unmapped indices read as zero with a slave error instead of aliasing a register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ACR_RESP_OKAY;
      unique case (r_idx)
        `ACR_IDX_CONFIG: s_axi_rdata <= {16'h0000, ch0_config};
        `ACR_IDX_OCAL_HIGH: s_axi_rdata <= {16'h0000, ch0_offset_cal_high};
        `ACR_IDX_OCAL_LOW: s_axi_rdata <= {16'h0000, ch0_offset_cal_low};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `ACR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Datapath outputs are registered copies, one cycle behind the registers.
  // Being flip-flops, they show downstream logic no decode glitches.
  // The phase field is exported raw; its two's complement meaning is applied downstream.
  // The upper offset register is the most significant part of the signed 24-bit word.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_config_out <= '0;
      ch0_offset_value <= 24'h000000;
      ch0_dc_removal_active <= 1'b0;
    end else begin
      ch0_config_out.ch0_phase_delay <= ch0_config[`ACR_PHASE_MSB:`ACR_PHASE_LSB];
      ch0_config_out.ch0_highpass_bypass <= ch0_config[`ACR_BYPASS_BIT];
      ch0_config_out.ch0_input_select <=
        acr_input_t'(ch0_config[`ACR_MUX_MSB:`ACR_MUX_LSB]);
      ch0_offset_value <= {ch0_offset_cal_high, ch0_offset_cal_low[15:8]};
      // Bypass overrides the global filter setting for this channel only.
      ch0_dc_removal_active <= global_dc_removal_setting &&
                               !ch0_config[`ACR_BYPASS_BIT];
    end
  end
endmodule : acr_regs
`default_nettype wire

/* tb/acr_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module acr_regs_properties
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire acr_config_t ch0_config_out,
  input wire logic signed [23:0] ch0_offset_value,
  input wire logic global_dc_removal_setting,
  input wire logic ch0_dc_removal_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] ar;
  // Remembers the read address so each read answer can be tied to its source register.
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) ar <= s_axi_araddr;
  end
  a_reset_zero: assert property (!$past(rst_n) |->
    ch0_offset_value == '0 && ch0_config_out == '0 && !ch0_dc_removal_active)
    else $error("outputs not zero after reset");
  // The reset level is part of the window, so the edge that releases reset starts no attempt.
  a_dc_follow: assert property ((rst_n && $stable(global_dc_removal_setting) &&
    $stable(ch0_config_out))[*2] |->
    ch0_dc_removal_active == (global_dc_removal_setting && !ch0_config_out.ch0_highpass_bypass))
    else $error("filter enable wrong");
  a_bypass_blocks: assert property ($rose(ch0_config_out.ch0_highpass_bypass) |=>
    !ch0_dc_removal_active)
    else $error("bypass ignored");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0)
    else $error("read upper half not zero");
  a_hi_read: assert property (s_axi_rvalid && ar == 6'h28 |->
    s_axi_rdata[15:0] == ch0_offset_value[23:8])
    else $error("upper offset mismatch");
  a_lo_read: assert property (s_axi_rvalid && ar == 6'h2c |->
    s_axi_rdata[15:0] == {ch0_offset_value[7:0], 8'h00})
    else $error("lower offset mismatch");
  a_cfg_read: assert property (s_axi_rvalid && ar == 6'h24 |->
    s_axi_rdata[15:0] == {ch0_config_out[12:3], 3'h0, ch0_config_out[2:0]})
    else $error("config read mismatch");
  a_change_cause: assert property ($changed(ch0_offset_value) ||
    $changed(ch0_config_out) |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == 2'h0)
    else $error("output changed without write");
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_lo: cover property (s_axi_rvalid && ar == 6'h2c);
  c_dc: cover property ($rose(ch0_dc_removal_active));
endmodule : acr_regs_properties
bind acr_regs acr_regs_properties u_props (.*);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import acr_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, global_dc_removal_setting = 1'b0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ch0_dc_removal_active;
  acr_config_t ch0_config_out;
  logic signed [23:0] ch0_offset_value;
  logic [15:0] lf = 16'h000a, v, m [16];
  int n_fail = 0, compares = 0, cyc = 0;
  acr_regs uut (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx
  // Unmapped indices get an all-zero mask, so the model keeps them reading zero.
  function automatic logic [15:0] mk(input int i);
    return i == 9 ? 16'hffc7 : i == 10 ? 16'hffff : i == 11 ? 16'hff00 : 16'h0000;
  endfunction : mk
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [5:0] a, input logic [15:0] x, input logic [3:0] sb);
    s_axi_awaddr <= a;
    s_axi_wdata <= {lf, x};
    s_axi_wstrb <= sb;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  initial begin
    m = '{default: '0};
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      int a;
      logic [3:0] sb;
      logic [15:0] lm;
      a = 9 + i % 4;
      lf = nx(lf);
      // Fifteen of the twenty writes use only strobes 1:0, so the strobe merge is exercised.
      sb = lf[7] ? 4'hf : {2'b00, lf[1:0]};
      lm = {{8{sb[1]}}, {8{sb[0]}}};
      v = {lf[15:2], 2'(i / 4)} & mk(a);
      global_dc_removal_setting <= lf[3];
      rd(6'(a * 4));
      chk(d, m[a]);
      wr(6'(a * 4), v, sb);
      chk(r, a > 11 ? 2'h2 : 2'h0);
      m[a] = (v & lm) | (m[a] & ~lm);
      rd(6'(a * 4));
      chk(d, m[a]);
      chk(r, a > 11 ? 2'h2 : 2'h0);
      repeat (2) @(posedge clk);
      chk(ch0_config_out, {m[9][15:6], m[9][2:0]});
      // The offset port is signed, so it is widened by hand to avoid sign extension.
      chk({8'h00, ch0_offset_value}, {8'h00, m[10], m[11][15:8]});
      chk(ch0_dc_removal_active, lf[3] & ~m[9][2]);
    end
    // A reset in mid-run must clear whatever the writes left behind.
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    m = '{default: '0};
    @(posedge clk);
    for (int a = 9; a < 12; a++) begin
      rd(6'(a * 4));
      chk(d, m[a]);
    end
    chk({8'h00, ch0_offset_value}, {8'h00, m[10], m[11][15:8]});
    end_sim();
  end
endmodule : tb
`default_nettype wire
